// ===== eeprom_cfg.svh
// constants for the serial memory write commit and recovery block
// Overview of operation
// - power-on clear resets all internal state
// - ignore every transaction during initialisation
// - start condition always resets serial interface
// - low supply at stop cancels write
// - write only after acked byte, then stop
// - stop elsewhere discards the command
// - start mid-command aborts, restarts address reception
// - dummy clocks release any SDA drive
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
`define EE_DEV_ADDR   7'h50
`define EE_BYTE_BITS  4'h8
`define EE_RD_BIT     0
`define EE_SCL_IDX    1
`define EE_SDA_IDX    0
`define EE_PIN_IDLE   2'h3
`endif

// ===== eeprom_pkg.sv
// types shared by the serial memory control block
package eeprom_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACKA, ST_WADR, ST_ACKW, ST_WDAT, ST_ACKD,
        ST_RDAT, ST_RACK, ST_WAIT
    } ser_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } wr_byte_s;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_s;
endpackage : eeprom_pkg

// ===== pin_sampler.sv
// three-stage pin sampler, level changes once stages two and three agree
`timescale 1ns/1ps
module pin_sampler (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // raw pins and sampled levels
    input  wire eeprom_pkg::bus_pins_s pinsIn,
    output eeprom_pkg::bus_pins_s      level
);
    logic [1:0] rawBits;
    logic [1:0] levelBits;

    assign rawBits = {pinsIn.scl, pinsIn.sda};
    assign level   = levelBits;

    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_pin
            logic stage1_r;
            logic stage2_r;
            logic stage3_r;
            logic level_r;
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    stage1_r <= 1'b1;
                    stage2_r <= 1'b1;
                    stage3_r <= 1'b1;
                end
                else
                begin
                    stage1_r <= rawBits[i];
                    stage2_r <= stage1_r;
                    stage3_r <= stage2_r;
                end
            end
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                    level_r <= 1'b1;
                else if (stage2_r == stage3_r)
                    level_r <= stage3_r;
            end
            assign levelBits[i] = level_r;
        end
    endgenerate
endmodule : pin_sampler

// ===== eeprom_write_commit.sv
// serial memory slave control: init lockout, abort, write commit or discard
`timescale 1ns/1ps
`include "eeprom_cfg.svh"
module eeprom_write_commit (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // supply monitor flags
    input  wire logic                  initBusy,
    input  wire logic                  lowSupply,
    // bus pins, SDA open drain
    input  wire eeprom_pkg::bus_pins_s pinsIn,
    output logic                       sdaOut,
    output logic                       sdaOe,
    // array side
    input  wire logic [7:0]            rdData,
    output logic [7:0]                 rdAddr,
    output eeprom_pkg::wr_byte_s       wrByte,
    output logic                       commitPulse,
    output logic                       discardPulse
);
    eeprom_pkg::bus_pins_s  level;
    eeprom_pkg::bus_pins_s  levelPrev_r;
    eeprom_pkg::ser_state_e state_r;
    logic [3:0]             bitCnt_r;
    logic [7:0]             shift_r;
    logic [7:0]             wordAddr_r;
    logic [7:0]             byteCnt_r;
    logic                   mAck_r;
    logic                   sdaOe_r;
    logic                   clear;
    logic                   sclRise;
    logic                   sclFall;
    logic                   startDet;
    logic                   stopDet;
    logic                   inWrite;
    logic                   stopAfterAck;

    pin_sampler u_sampler (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinsIn  (pinsIn),
        .level   (level)
    );

    // init in progress holds everything but the pin sampler and levelPrev_r at its initial value
    assign clear    = sys_rst | initBusy;
    assign sclRise  = level.scl & ~levelPrev_r.scl;
    assign sclFall  = ~level.scl & levelPrev_r.scl;
    assign startDet = level.scl & levelPrev_r.scl & levelPrev_r.sda & ~level.sda;
    assign stopDet  = level.scl & levelPrev_r.scl & ~levelPrev_r.sda & level.sda;
    assign inWrite  = (state_r == eeprom_pkg::ST_WADR) || (state_r == eeprom_pkg::ST_ACKW)
                   || (state_r == eeprom_pkg::ST_WDAT) || (state_r == eeprom_pkg::ST_ACKD);
    // stop right after a data acknowledge: at most the clock edge of the stop itself seen
    assign stopAfterAck = (state_r == eeprom_pkg::ST_WDAT) && (bitCnt_r <= 4'h1)
                       && (byteCnt_r != 8'h00);
    assign sdaOut   = 1'b0;
    assign sdaOe    = sdaOe_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            levelPrev_r <= `EE_PIN_IDLE;
        else
            levelPrev_r <= level;
    end

    // protocol state, bit counter and shift register
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            state_r  <= eeprom_pkg::ST_IDLE;
            bitCnt_r <= 4'h0;
            shift_r  <= 8'h00;
            mAck_r   <= 1'b0;
        end
        else if (startDet)
        begin
            state_r  <= eeprom_pkg::ST_ADDR;
            bitCnt_r <= 4'h0;
        end
        else if (stopDet)
        begin
            state_r  <= eeprom_pkg::ST_IDLE;
            bitCnt_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                eeprom_pkg::ST_ADDR, eeprom_pkg::ST_WADR, eeprom_pkg::ST_WDAT:
                begin
                    if (sclRise)
                    begin
                        shift_r  <= {shift_r[6:0], level.sda};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end
                    else if (sclFall && bitCnt_r == `EE_BYTE_BITS)
                    begin
                        bitCnt_r <= 4'h0;
                        if (state_r == eeprom_pkg::ST_ADDR)
                            state_r <= (shift_r[7:1] == `EE_DEV_ADDR) ? eeprom_pkg::ST_ACKA
                                                                     : eeprom_pkg::ST_WAIT;
                        else if (state_r == eeprom_pkg::ST_WADR)
                            state_r <= eeprom_pkg::ST_ACKW;
                        else
                            state_r <= eeprom_pkg::ST_ACKD;
                    end
                end
                eeprom_pkg::ST_ACKA:
                begin
                    if (sclFall)
                    begin
                        if (shift_r[`EE_RD_BIT])
                        begin
                            state_r <= eeprom_pkg::ST_RDAT;
                            shift_r <= rdData;
                        end
                        else
                            state_r <= eeprom_pkg::ST_WADR;
                    end
                end
                eeprom_pkg::ST_ACKW, eeprom_pkg::ST_ACKD:
                begin
                    if (sclFall)
                        state_r <= eeprom_pkg::ST_WDAT;
                end
                eeprom_pkg::ST_RDAT:
                begin
                    if (sclRise)
                        bitCnt_r <= bitCnt_r + 4'h1;
                    else if (sclFall && bitCnt_r == `EE_BYTE_BITS)
                    begin
                        state_r  <= eeprom_pkg::ST_RACK;
                        bitCnt_r <= 4'h0;
                    end
                    else if (sclFall)
                        shift_r <= {shift_r[6:0], 1'b0};
                end
                eeprom_pkg::ST_RACK:
                begin
                    if (sclRise)
                        mAck_r <= ~level.sda;
                    else if (sclFall && mAck_r)
                    begin
                        state_r <= eeprom_pkg::ST_RDAT;
                        shift_r <= rdData;
                    end
                    else if (sclFall)
                        state_r <= eeprom_pkg::ST_WAIT;
                end
                eeprom_pkg::ST_IDLE, eeprom_pkg::ST_WAIT:
                    state_r <= state_r;
                default:
                    state_r <= eeprom_pkg::ST_IDLE;
            endcase
        end
    end

    // SDA drive: acks and read data only, released on every start and stop
    always_ff @(posedge clk)
    begin
        if (clear || startDet || stopDet)
            sdaOe_r <= 1'b0;
        else if (sclFall)
        begin
            case (state_r)
                eeprom_pkg::ST_ADDR:
                    sdaOe_r <= (bitCnt_r == `EE_BYTE_BITS) && (shift_r[7:1] == `EE_DEV_ADDR);
                eeprom_pkg::ST_WADR, eeprom_pkg::ST_WDAT:
                    sdaOe_r <= (bitCnt_r == `EE_BYTE_BITS);
                eeprom_pkg::ST_ACKA:
                    sdaOe_r <= shift_r[`EE_RD_BIT] && !rdData[7];
                eeprom_pkg::ST_RDAT:
                    sdaOe_r <= (bitCnt_r != `EE_BYTE_BITS) && !shift_r[6];
                eeprom_pkg::ST_RACK:
                    sdaOe_r <= mAck_r && !rdData[7];
                default:
                    sdaOe_r <= 1'b0;
            endcase
        end
    end

    // word address pointer and read address
    always_ff @(posedge clk)
    begin
        if (clear)
            wordAddr_r <= 8'h00;
        else if (!startDet && !stopDet && sclFall && bitCnt_r == `EE_BYTE_BITS)
        begin
            if (state_r == eeprom_pkg::ST_WADR)
                wordAddr_r <= shift_r;
            else if (state_r == eeprom_pkg::ST_WDAT || state_r == eeprom_pkg::ST_RDAT)
                wordAddr_r <= wordAddr_r + 8'h01;
        end
    end
    assign rdAddr = wordAddr_r;

    // acknowledged data bytes go to the page latch, not the array
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            wrByte    <= '0;
            byteCnt_r <= 8'h00;
        end
        else if (startDet || stopDet)
        begin
            wrByte.valid <= 1'b0;
            byteCnt_r    <= 8'h00;
        end
        else if (state_r == eeprom_pkg::ST_WDAT && sclFall && bitCnt_r == `EE_BYTE_BITS)
        begin
            wrByte.valid <= 1'b1;
            wrByte.addr  <= wordAddr_r;
            wrByte.data  <= shift_r;
            if (byteCnt_r != 8'hFF)
                byteCnt_r <= byteCnt_r + 8'h01;
        end
        else
            wrByte.valid <= 1'b0;
    end

    // commit decided at stop, discard at stop or start; a start never commits
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            commitPulse  <= 1'b0;
            discardPulse <= 1'b0;
        end
        else
        begin
            commitPulse  <= stopDet && stopAfterAck && !lowSupply;
            discardPulse <= (stopDet && inWrite && !(stopAfterAck && !lowSupply))
                         || (startDet && inWrite);
        end
    end

    sequence s_stopAfterAck;
        stopDet && stopAfterAck;
    endsequence

    sequence s_dataNack;
        state_r == eeprom_pkg::ST_RACK && sclFall && !mAck_r && !startDet && !stopDet;
    endsequence

    chk_init_silent: assert property (@(posedge clk) disable iff (sys_rst)
        initBusy |=> !sdaOe && !commitPulse && state_r == eeprom_pkg::ST_IDLE)
        else $error("activity during initialisation");
    chk_reset_idle: assert property (@(posedge clk) disable iff (initBusy)
        $past(sys_rst) |-> state_r == eeprom_pkg::ST_IDLE && !sdaOe)
        else $error("state not cleared by reset");
    chk_start_resets: assert property (@(posedge clk) disable iff (clear)
        startDet |=> state_r == eeprom_pkg::ST_ADDR && !sdaOe && bitCnt_r == 4'h0)
        else $error("start did not restart address reception");
    chk_low_cancel: assert property (@(posedge clk) disable iff (clear)
        s_stopAfterAck ##0 lowSupply |=> !commitPulse && discardPulse)
        else $error("write committed under low supply");
    chk_commit_cause: assert property (@(posedge clk) disable iff (clear)
        commitPulse |-> $past(stopDet) && !$past(lowSupply) && $past(byteCnt_r) != 8'h00
                     && $past(state_r) == eeprom_pkg::ST_WDAT && $past(bitCnt_r) <= 4'h1)
        else $error("commit without stop after data acknowledge");
    chk_commit_good: assert property (@(posedge clk) disable iff (clear)
        s_stopAfterAck ##0 !lowSupply |=> commitPulse ##1 !commitPulse)
        else $error("valid write not committed as one pulse");
    chk_stop_midbyte: assert property (@(posedge clk) disable iff (clear)
        stopDet && state_r == eeprom_pkg::ST_WDAT && bitCnt_r > 4'h1
        |=> discardPulse && !commitPulse)
        else $error("mid-byte stop not discarded");
    chk_start_abort: assert property (@(posedge clk) disable iff (clear)
        startDet && inWrite |=> !commitPulse && discardPulse && byteCnt_r == 8'h00)
        else $error("start did not abort command");
    chk_nack_release: assert property (@(posedge clk) disable iff (clear)
        s_dataNack |=> (state_r == eeprom_pkg::ST_WAIT && !sdaOe) [*2])
        else $error("SDA still driven after dummy clock");
    chk_no_busy: assert property (@(posedge clk) disable iff (clear)
        (commitPulse || discardPulse) && !$past(startDet) |-> state_r == eeprom_pkg::ST_IDLE)
        else $error("not idle after write decision");
endmodule : eeprom_write_commit

// ===== bus_master_model.sv
// two-wire bus master model driving SCL and SDA
`timescale 1ns/1ps
module bus_master_model (
    // clock
    input  wire logic clk,
    // bus lines
    input  wire logic sda,
    output logic      scl,
    output logic      sdaRel
);
    initial
    begin
        scl    = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic half();
        repeat (8) @(negedge clk);
    endtask : half
    // data set while SCL low, line sampled while SCL high
    task automatic bit_io(input logic b, output logic got);
        half();
        sdaRel = b;
        half();
        scl = 1'b1;
        half();
        got = sda;
        half();
        scl = 1'b0;
    endtask : bit_io
    task automatic start();
        half();
        sdaRel = 1'b1;
        half();
        scl = 1'b1;
        half();
        sdaRel = 1'b0;
        half();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        half();
        sdaRel = 1'b0;
        half();
        scl = 1'b1;
        half();
        sdaRel = 1'b1;
        half();
    endtask : stop
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], g);
        bit_io(1'b1, g);
        ack = ~g;
    endtask : put_byte
    task automatic get_byte(input logic mack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, g);
            d[i] = g;
        end
        bit_io(~mack, g);
    endtask : get_byte
    // device may hold SDA low: start, then nine dummy clocks, then start and stop
    task automatic phase_adjust();
        logic g;
        start();
        repeat (9) bit_io(1'b1, g);
        start();
        stop();
    endtask : phase_adjust
endmodule : bus_master_model

// ===== testbench.sv
// self-checking bench for the write commit and recovery block
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
    $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    logic                 clk;
    logic                 sysRst;
    logic                 initBusy;
    logic                 lowSupply;
    logic                 scl;
    logic                 sdaRel;
    logic                 sdaWire;
    logic                 sdaOut;
    logic                 sdaOe;
    logic [7:0]           rdData;
    logic [7:0]           rdAddr;
    eeprom_pkg::wr_byte_s wrByte;
    eeprom_pkg::wr_byte_s lastWr;
    eeprom_pkg::bus_pins_s pins;
    logic                 commitPulse;
    logic                 discardPulse;
    int                   errCount;
    int                   samplesChecked;
    int                   commits;
    int                   discards;
    int                   wrs;
    // pulled-up data line
    assign sdaWire  = (sdaOe || !sdaRel) ? 1'b0 : 1'b1;
    assign pins.scl = scl;
    assign pins.sda = sdaWire;
    assign rdData   = rdAddr ^ 8'h5A;
    eeprom_write_commit uut (.clk(clk), .sys_rst(sysRst), .initBusy(initBusy),
        .lowSupply(lowSupply), .pinsIn(pins), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .rdData(rdData), .rdAddr(rdAddr), .wrByte(wrByte),
        .commitPulse(commitPulse), .discardPulse(discardPulse));
    bus_master_model master (.clk(clk), .sda(sdaWire), .scl(scl), .sdaRel(sdaRel));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (commitPulse === 1'b1) commits++;
        if (discardPulse === 1'b1) discards++;
        if (wrByte.valid === 1'b1)
        begin
            wrs++;
            lastWr = wrByte;
        end
    end
    task automatic wrapUp();
        $display("checks %0d errors %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrapUp
    task automatic clr();
        @(negedge clk);
        commits  = 0;
        discards = 0;
        wrs      = 0;
    endtask : clr
    task automatic wr(input logic [7:0] w, input logic [7:0] d, input logic fin);
        logic a1, a2, a3;
        master.start();
        master.put_byte(8'hA0, a1);
        master.put_byte(w, a2);
        master.put_byte(d, a3);
        `CHK(a1 & a2 & a3, 1'b1)
        if (fin)
            master.stop();
        repeat (4) @(negedge clk);
    endtask : wr
    task automatic t_reset();
        logic a;
        `CHK(sdaOe, 1'b0)
        `CHK(sdaOut, 1'b0)
        `CHK(rdAddr, 8'h00)
        `CHK(wrByte, 17'h0_0000)
        clr();
        master.start();
        master.put_byte(8'hA0, a);
        master.put_byte(8'h07, a);
        sysRst = 1'b1;
        repeat (4) @(negedge clk);
        sysRst = 1'b0;
        master.stop();
        `CHK(commits + discards, 0)
    endtask : t_reset
    task automatic t_init();
        logic a;
        initBusy = 1'b1;
        clr();
        master.start();
        master.put_byte(8'hA0, a);
        `CHK(a, 1'b0)
        master.stop();
        `CHK(commits + discards, 0)
        initBusy = 1'b0;
    endtask : t_init
    task automatic t_write();
        logic a;
        clr();
        wr(8'h3C, 8'hA5, 1'b1);
        `CHK({commits, discards, wrs}, {32'd1, 32'd0, 32'd1})
        `CHK({lastWr.addr, lastWr.data}, 16'h3CA5)
        // stop after the word address only: no data byte, no commit
        clr();
        master.start();
        master.put_byte(8'hA0, a);
        master.put_byte(8'h3D, a);
        master.stop();
        repeat (4) @(negedge clk);
        `CHK({commits, discards, wrs}, {32'd0, 32'd1, 32'd0})
    endtask : t_write
    task automatic t_low();
        clr();
        wr(8'h40, 8'h11, 1'b0);
        lowSupply = 1'b1;
        master.stop();
        repeat (4) @(negedge clk);
        lowSupply = 1'b0;
        `CHK({commits, discards}, {32'd0, 32'd1})
        clr();
        wr(8'h41, 8'h22, 1'b1);
        `CHK(commits, 1)
    endtask : t_low
    task automatic t_midstop();
        logic g;
        clr();
        wr(8'h50, 8'h33, 1'b0);
        clr();
        repeat (3) master.bit_io(1'b0, g);
        master.stop();
        repeat (4) @(negedge clk);
        `CHK({commits, discards, wrs}, {32'd0, 32'd1, 32'd0})
    endtask : t_midstop
    task automatic t_abort();
        logic a;
        logic g;
        clr();
        master.start();
        master.put_byte(8'hA0, a);
        master.put_byte(8'h20, a);
        repeat (2) master.bit_io(1'b1, g);
        wr(8'h21, 8'h44, 1'b0);
        `CHK({discards, wrs}, {32'd1, 32'd1})
        master.stop();
        repeat (4) @(negedge clk);
        `CHK({lastWr.addr, commits}, {8'h21, 32'd1})
    endtask : t_abort
    task automatic t_recover();
        logic       a;
        logic       g;
        logic [7:0] d;
        master.start();
        master.put_byte(8'hA0, a);
        master.put_byte(8'h10, a);
        master.start();
        master.put_byte(8'hA1, a);
        master.get_byte(1'b1, d);
        `CHK(d, 8'h4A)
        `CHK(rdAddr, 8'h11)
        repeat (2) master.bit_io(1'b1, g);
        master.phase_adjust();
        `CHK(sdaOe, 1'b0)
        clr();
        wr(8'h66, 8'h5C, 1'b1);
        `CHK(commits, 1)
    endtask : t_recover
    initial
    begin
        sysRst    = 1'b1;
        initBusy  = 1'b0;
        lowSupply = 1'b0;
        errCount  = 0;
        samplesChecked = 0;
        repeat (6) @(negedge clk);
        sysRst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_init();
        t_write();
        t_low();
        t_midstop();
        t_abort();
        t_recover();
        wrapUp();
    end
    initial
    begin
        #500_000;
        errCount++;
        wrapUp();
    end
endmodule : testbench
